/* File: src/exec_pkg.sv */
// package: opcode patterns, field positions, widths and states of the execution block
package exec_pkg;
  // word and field widths
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned PC_W = 13;
  localparam int unsigned LIT_W = 11;
  localparam int unsigned LATCH_W = 8;
  // field positions inside the instruction word
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned OP6_HI = 13;
  localparam int unsigned OP6_LO = 8;
  localparam int unsigned OP3_LO = 11;
  // upper latch bits copied into pc bits 12:11
  localparam int unsigned LATCH_HI = 4;
  localparam int unsigned LATCH_LO = 3;
  // opcode patterns
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_INC = 6'h0A;
  localparam logic [2:0] OP_JUMP = 3'h5;
  // register reset values and one-step constants
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // decoded kind of an instruction word
  typedef enum logic [1:0] {
    KIND_OTHER = 2'h0,
    KIND_DEC = 2'h1,
    KIND_INC = 2'h2,
    KIND_JUMP = 2'h3
  } kind_t;
  // control states, gray along idle -> exec -> flush
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_FLUSH = 2'h3
  } state_t;
endpackage

/* File: src/file_reg_if.sv */
// interface: access port between the execution core and the file register array
`timescale 1ns/1ns
interface file_reg_if;
  logic [exec_pkg::ADDR_W-1:0] addr; // read and write address
  logic [exec_pkg::DATA_W-1:0] wdata; // write data
  logic we; // write strobe
  logic [exec_pkg::DATA_W-1:0] rdata; // registered read data
  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

/* File: src/file_reg_array.sv */
// memory: 128 by 8 file register array with registered read data
`timescale 1ns/1ns
module file_reg_array (
  // clock
  input wire logic ref_clk,
  // access port
  file_reg_if.mem port
);
  // storage, deliberately without reset so it maps onto ram
  logic [exec_pkg::DATA_W-1:0] cells [0:(1<<exec_pkg::ADDR_W)-1];

  // write and read share one address; read shows the old contents
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
    port.rdata <= cells[port.addr];
  end
endmodule

/* File: src/exec_unit.sv */
// execution unit for decrement-skip, increment and jump instructions
// Behaviour
// (RULE1) decrement-skip reads file reg 0..127, subtracts one
// (RULE2) destination bit 0 to accumulator, 1 to file
// (RULE3) decode decrement-skip, test zero, keep flags
// (RULE4) zero result discards the already fetched instruction
// (RULE5) skip runs a no-op: two cycles else one
// (RULE6) increment adds one, updates zero flag, no skip
// (RULE7) jump is unconditional and keeps all flags
// (RULE8) jump loads 11-bit literal into pc 10:0
// (RULE9) jump copies latch bits 4:3 into pc 12:11
// (RULE10) jump takes two cycles, discards sequential fetch
// (RULE11) results wrap modulo 256
`timescale 1ns/1ns
module exec_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // instruction stream from fetch
  input wire logic [exec_pkg::INSTR_W-1:0] instr,
  input wire logic instr_valid,
  output logic instr_ready,
  // upper program-counter latch
  input wire logic [exec_pkg::LATCH_W-1:0] upper_pc_latch,
  // file register preload port
  input wire logic [exec_pkg::ADDR_W-1:0] preload_addr,
  input wire logic [exec_pkg::DATA_W-1:0] preload_data,
  input wire logic preload_valid,
  output logic preload_ready,
  // architectural state
  output logic [exec_pkg::PC_W-1:0] pc,
  output logic [exec_pkg::DATA_W-1:0] acc,
  output logic zero_flag,
  // per-instruction results
  output logic [exec_pkg::DATA_W-1:0] result_data,
  output logic result_valid,
  output logic result_to_file,
  output logic discard
);

  // classify an instruction word; only the kind of an accepted word is used
  function automatic exec_pkg::kind_t kind_of(input logic [exec_pkg::INSTR_W-1:0] w);
    exec_pkg::kind_t k;
    k = exec_pkg::KIND_OTHER;
    if (w[exec_pkg::OP6_HI:exec_pkg::OP6_LO] == exec_pkg::OP_DEC_SKIP) begin
      k = exec_pkg::KIND_DEC;
    end else if (w[exec_pkg::OP6_HI:exec_pkg::OP6_LO] == exec_pkg::OP_INC) begin
      k = exec_pkg::KIND_INC;
    end else if (w[exec_pkg::OP6_HI:exec_pkg::OP3_LO] == exec_pkg::OP_JUMP) begin
      k = exec_pkg::KIND_JUMP;
    end
    return k;
  endfunction

  // file register access channel
  file_reg_if fr ();

  // file register array
  file_reg_array u_regs (
    .ref_clk(ref_clk),
    .port(fr.mem)
  );

  // control state
  exec_pkg::state_t state; // current phase
  exec_pkg::state_t next_state;
  logic op_dec; // latched: instruction in exec is decrement-skip
  logic next_op_dec;
  logic op_dest; // latched destination bit
  logic next_op_dest;
  logic [exec_pkg::ADDR_W-1:0] op_addr; // latched file address
  logic [exec_pkg::ADDR_W-1:0] next_op_addr;
  logic flush_jump; // flush belongs to a jump, so pc must not advance
  logic next_flush_jump;
  // architectural state next values
  logic [exec_pkg::PC_W-1:0] next_pc;
  logic [exec_pkg::DATA_W-1:0] next_acc;
  logic next_zero_flag;
  logic [exec_pkg::DATA_W-1:0] next_result_data;
  logic next_result_valid;
  logic next_result_to_file;
  // combinational helpers
  exec_pkg::kind_t in_kind; // kind of the word now offered
  logic [exec_pkg::DATA_W-1:0] alu_out; // wrapped increment or decrement
  logic take; // instruction accepted this cycle

  // one word per cycle may be taken outside exec; exec must finish the file access
  assign instr_ready = (state != exec_pkg::ST_EXEC);
  assign take = instr_ready && instr_valid;
  assign in_kind = kind_of(instr);
  // the fetched word is dropped whenever it arrives during a flush
  assign discard = (state == exec_pkg::ST_FLUSH) && instr_valid; // RULE4
  // preload may not collide with a write back from exec
  assign preload_ready = (state != exec_pkg::ST_EXEC);

  // modulo-256 arithmetic on the value read from the file
  always_comb begin
    if (op_dec) begin
      alu_out = 8'(fr.rdata - exec_pkg::ONE); // RULE1 RULE11
    end else begin
      alu_out = 8'(fr.rdata + exec_pkg::ONE); // RULE11
    end
  end

  // file register port: read address during accept, write back in exec
  always_comb begin
    fr.addr = preload_addr;
    fr.wdata = preload_data;
    fr.we = 1'b0;
    if (state == exec_pkg::ST_EXEC) begin
      // the latched operand address is both read source and write target
      fr.addr = op_addr;
      fr.wdata = alu_out;
      fr.we = op_dest; // RULE2
    end else if (take) begin
      // start the read now so data arrive exactly when exec begins
      fr.addr = instr[exec_pkg::ADDR_W-1:0]; // RULE1
    end else if (preload_valid) begin
      // preload only uses idle or flush cycles with no instruction offered
      fr.we = 1'b1;
    end
  end

  // next state and datapath values
  always_comb begin
    next_state = state;
    next_op_dec = op_dec;
    next_op_dest = op_dest;
    next_op_addr = op_addr;
    next_flush_jump = flush_jump;
    next_pc = pc;
    next_acc = acc;
    next_zero_flag = zero_flag;
    next_result_data = result_data;
    next_result_valid = 1'b0;
    next_result_to_file = result_to_file;
    case (state)
      exec_pkg::ST_IDLE: begin
        if (take) begin
          // every accepted word except a jump moves the fetch address on by one
          next_pc = pc + exec_pkg::PC_STEP;
          case (in_kind)
            exec_pkg::KIND_DEC, exec_pkg::KIND_INC: begin
              // operand read already issued; latch what exec needs
              next_op_dec = (in_kind == exec_pkg::KIND_DEC); // RULE3
              next_op_dest = instr[exec_pkg::DEST_BIT];
              next_op_addr = instr[exec_pkg::ADDR_W-1:0];
              next_state = exec_pkg::ST_EXEC;
            end
            exec_pkg::KIND_JUMP: begin
              // new pc from the latch and the literal, flags untouched
              next_pc = {upper_pc_latch[exec_pkg::LATCH_HI:exec_pkg::LATCH_LO],
                         instr[exec_pkg::LIT_W-1:0]}; // RULE7 RULE8 RULE9
              next_flush_jump = 1'b1;
              next_state = exec_pkg::ST_FLUSH; // RULE10
            end
            default: begin
              // other instructions belong to other units
              next_state = exec_pkg::ST_IDLE;
            end
          endcase
        end
      end
      exec_pkg::ST_EXEC: begin
        // write the result to the chosen destination
        next_result_data = alu_out;
        next_result_valid = 1'b1;
        next_result_to_file = op_dest;
        if (!op_dest) begin
          next_acc = alu_out; // RULE2
        end
        if (op_dec) begin
          // decrement-skip leaves the zero flag alone
          if (alu_out == 8'h00) begin
            next_flush_jump = 1'b0;
            next_state = exec_pkg::ST_FLUSH; // RULE4 RULE5
          end else begin
            next_state = exec_pkg::ST_IDLE; // RULE5
          end
        end else begin
          // increment never skips
          next_zero_flag = (alu_out == 8'h00); // RULE6
          next_state = exec_pkg::ST_IDLE; // RULE6
        end
      end
      exec_pkg::ST_FLUSH: begin
        // the fetched word runs as a no-op and is dropped
        if (instr_valid) begin
          if (!flush_jump) begin
            // skipped word was at pc; continue after it
            next_pc = pc + exec_pkg::PC_STEP; // RULE4
          end
          // a jump keeps its target; the dropped word was sequential
          next_flush_jump = 1'b0;
          next_state = exec_pkg::ST_IDLE; // RULE10
        end
      end
      default: begin
        next_state = exec_pkg::ST_IDLE;
      end
    endcase
  end

  // register all state; synchronous active-low reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= exec_pkg::ST_IDLE;
      op_dec <= 1'b0;
      op_dest <= 1'b0;
      op_addr <= '0;
      flush_jump <= 1'b0;
      pc <= exec_pkg::PC_RESET;
      acc <= exec_pkg::ACC_RESET;
      zero_flag <= 1'b0;
      result_data <= exec_pkg::ACC_RESET;
      result_valid <= 1'b0;
      result_to_file <= 1'b0;
    end else begin
      state <= next_state;
      op_dec <= next_op_dec;
      op_dest <= next_op_dest;
      op_addr <= next_op_addr;
      flush_jump <= next_flush_jump;
      pc <= next_pc;
      acc <= next_acc;
      zero_flag <= next_zero_flag;
      result_data <= next_result_data;
      result_valid <= next_result_valid;
      result_to_file <= next_result_to_file;
    end
  end

  // checks on the execution sequence
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // decrement result is the read value minus one, modulo 256
  dec_result_a: assert property ( // RULE1
    (state == exec_pkg::ST_EXEC && op_dec) |=>
      result_valid && result_data == 8'($past(fr.rdata) - 8'h01))
    else $error("decrement result wrong");

  // destination bit 0 lands in the accumulator, 1 leaves it alone
  dest_select_a: assert property ( // RULE2
    (state == exec_pkg::ST_EXEC) |=>
      ($past(op_dest) ? ($stable(acc) && result_to_file) : (acc == result_data)))
    else $error("destination selection wrong");

  // decrement-skip keeps the zero flag
  dec_flags_a: assert property ( // RULE3
    (state == exec_pkg::ST_EXEC && op_dec) |=> $stable(zero_flag))
    else $error("decrement changed zero flag");

  // zero decrement discards the next word and advances pc past it by one
  // the fetcher may offer the skipped word any number of cycles after exec
  skip_discard_a: assert property ( // RULE4
    (state == exec_pkg::ST_FLUSH && !flush_jump && instr_valid) |->
      discard ##1 (pc == $past(pc) + 13'h0001 && instr_ready))
    else $error("skip did not discard");

  // nonzero decrement returns to idle at once; zero takes the extra cycle
  skip_cycles_a: assert property ( // RULE5
    (state == exec_pkg::ST_EXEC && op_dec) |=>
      (result_data == 8'h00) == (state == exec_pkg::ST_FLUSH))
    else $error("skip cycle count wrong");

  // increment updates zero flag and never skips
  inc_zero_a: assert property ( // RULE6
    (state == exec_pkg::ST_EXEC && !op_dec) |=>
      zero_flag == (result_data == 8'h00) && state == exec_pkg::ST_IDLE)
    else $error("increment zero flag wrong");

  // jump target built from latch and literal, flags kept
  jump_target_a: assert property ( // RULE7 RULE8 RULE9
    (state == exec_pkg::ST_IDLE && take && in_kind == exec_pkg::KIND_JUMP) |=>
      pc == {$past(upper_pc_latch[4:3]), $past(instr[10:0])} && $stable(zero_flag))
    else $error("jump target wrong");

  // jump spends a flush cycle and keeps its target across the discard
  jump_flush_a: assert property ( // RULE10
    (state == exec_pkg::ST_FLUSH && flush_jump && instr_valid) |->
      discard ##1 ($stable(pc) && state == exec_pkg::ST_IDLE))
    else $error("jump flush wrong");

  // increment of 0xFF wraps to zero
  inc_wrap_a: assert property ( // RULE11
    (state == exec_pkg::ST_EXEC && !op_dec && fr.rdata == 8'hFF) |=>
      result_data == 8'h00 && zero_flag)
    else $error("increment wrap wrong");

  // main scenarios
  skip_taken_c: cover property (
    (state == exec_pkg::ST_EXEC && op_dec && alu_out == 8'h00) ##[1:3] discard);
  jump_seen_c: cover property (
    (take && in_kind == exec_pkg::KIND_JUMP && state == exec_pkg::ST_IDLE) ##[1:3] discard);
  inc_wrap_c: cover property (
    state == exec_pkg::ST_EXEC && !op_dec && fr.rdata == 8'hFF);
  dec_to_file_c: cover property (
    state == exec_pkg::ST_EXEC && op_dec && op_dest);

endmodule

/* File: tb/dec_skip_inc_jump_exec_tb_top.sv */
// testbench: self-checking stimulus and result queue for the decrement-skip, increment, jump unit
`timescale 1ns/1ns
module dec_skip_inc_jump_exec_tb_top;
  logic ref_clk, resetn; // clock and synchronous active-low reset
  logic [13:0] instr; // offered instruction word
  logic instr_valid, instr_ready, preload_valid, preload_ready;
  logic [7:0] upper_pc_latch, preload_data, acc, result_data;
  logic [6:0] preload_addr;
  logic [12:0] pc;
  logic zero_flag, result_valid, result_to_file, discard;
  int failures, n_tests, cyc; // mismatches, comparisons, cycles
  logic [31:0] seed; // lfsr state
  logic [7:0] fm [128]; // bench copy of the file registers
  logic [8:0] notes [$]; // expected {to_file, data}, oldest first
  logic [8:0] note;
  logic [12:0] exp_pc;
  logic [7:0] exp_acc;
  logic exp_z;

  exec_unit i_dut (.ref_clk, .resetn, .instr, .instr_valid, .instr_ready, .upper_pc_latch,
    .preload_addr, .preload_data, .preload_valid, .preload_ready, .pc, .acc, .zero_flag,
    .result_data, .result_valid, .result_to_file, .discard);

  // free-running 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one preload write while the instruction port is quiet
  task automatic pre(logic [6:0] a, logic [7:0] v);
    @(negedge ref_clk);
    preload_addr = a;
    preload_data = v;
    preload_valid = 1'b1;
    fm[a] = v;
    @(negedge ref_clk);
    preload_valid = 1'b0;
  endtask

  // offer one word once ready; dd is the expected discard while offered
  task automatic send(logic [13:0] w, logic dd);
    @(negedge ref_clk);
    while (instr_ready !== 1'b1) @(negedge ref_clk);
    instr = w;
    instr_valid = 1'b1;
    #1 chk("discard", {12'h000, dd}, {12'h000, discard});
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask

  // increment or decrement-skip of file a, destination d
  task automatic op(logic inc, logic [6:0] a, logic d);
    logic [7:0] r;
    r = inc ? fm[a] + 8'h01 : fm[a] - 8'h01; // wraps at eight bits
    notes.push_back({d, r});
    send({5'h05, ~inc, d, a}, 1'b0);
    exp_pc = exp_pc + 13'h0001;
    chk("pc", exp_pc, pc);
    chk("instr_ready", 13'h0000, {12'h000, instr_ready});
    chk("preload_ready", 13'h0000, {12'h000, preload_ready});
    if (d)
      fm[a] = r;
    else
      exp_acc = r;
    if (inc)
      exp_z = (r == 8'h00);
    @(negedge ref_clk);
    chk("acc", {5'h00, exp_acc}, {5'h00, acc});
    chk("zero_flag", {12'h000, exp_z}, {12'h000, zero_flag});
    if (!inc && r == 8'h00) begin
      send(14'h3000, 1'b1);
      exp_pc = exp_pc + 13'h0001;
      chk("pc", exp_pc, pc);
    end
  endtask

  // jump to literal k with latch l, then the dropped word
  task automatic jump(logic [10:0] k, logic [7:0] l);
    upper_pc_latch = l;
    send({3'h5, k}, 1'b0);
    exp_pc = {l[4:3], k};
    chk("pc", exp_pc, pc);
    send(14'h3000, 1'b1);
    chk("pc", exp_pc, pc);
    chk("zero_flag", {12'h000, exp_z}, {12'h000, zero_flag});
  endtask

  // result watcher: each pulse takes the oldest note
  always @(negedge ref_clk) begin
    if (result_valid === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("unexpected result_valid: expected 0 seen 1");
      end else begin
        note = notes.pop_front();
        chk("result_data", {5'h00, note[7:0]}, {5'h00, result_data});
        chk("result_to_file", {12'h000, note[8]}, {12'h000, result_to_file});
      end
    end
  end

  // hang guard, well above the expected run of about a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 8000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    resetn = 1'b0;
    instr = 14'h0000;
    instr_valid = 1'b0;
    upper_pc_latch = 8'h00;
    preload_addr = 7'h00;
    preload_data = 8'h00;
    preload_valid = 1'b0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    seed = 32'hDFDB;
    exp_pc = 13'h0000;
    exp_acc = 8'h00;
    exp_z = 1'b0;
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    chk("pc", 13'h0000, pc);
    chk("preload_ready", 13'h0001, {12'h000, preload_ready});
    for (int i = 0; i < 128; i++) begin
      seed = nxt(seed);
      pre(i[6:0], seed[7:0]);
    end
    // boundaries: wrap up to zero, wrap down from zero, skip on both destinations
    pre(7'h7F, 8'hFF);
    op(1'b1, 7'h7F, 1'b1);
    op(1'b0, 7'h7F, 1'b1);
    pre(7'h00, 8'h01);
    op(1'b0, 7'h00, 1'b0);
    pre(7'h01, 8'h01);
    op(1'b0, 7'h01, 1'b1);
    op(1'b0, 7'h01, 1'b0);
    jump(11'h7FF, 8'h18);
    jump(11'h000, 8'hE7);
    for (int i = 0; i < 200; i++) begin
      seed = nxt(seed);
      case (seed[1:0])
        2'h0: op(1'b1, seed[14:8], seed[2]);
        2'h1: op(1'b0, seed[14:8], seed[2]);
        2'h2: jump(seed[26:16], seed[31:24]);
        default: begin
          send({2'h3, seed[27:16]}, 1'b0);
          exp_pc = exp_pc + 13'h0001;
          chk("pc", exp_pc, pc);
        end
      endcase
    end
    repeat (3) @(negedge ref_clk);
    chk("pending results", 13'h0000, 13'(notes.size()));
    close_out();
  end
endmodule
